/* src/crc_monitor.sv */
`timescale 1ns/1ps
module crc_monitor (
  input wire logic i_clk,             // Core clock
  input wire logic i_srst,            // Synchronous reset
  input wire logic i_ce,              // Clock enable
  input wire logic i_start,           // Pulse launched, timer zero
  input wire logic i_clear,           // Function disabled
  input wire logic i_tick,            // Sample valid
  input wire logic [7:0] i_sample,    // Signed converter sample
  input wire logic [7:0] i_win_start, // First qualified step
  input wire logic [7:0] i_win_stop,  // Last sampled step
  input wire logic i_min_mode,        // Track minimum
  input wire logic [6:0] i_thr,       // Threshold magnitude
  output logic [15:0] o_peak,         // {time, value}
  output logic [15:0] o_thr,          // {time, value}
  output logic o_busy                 // Timer running
);

  logic [7:0] time_r;
  logic peak_seen_r;
  logic thr_seen_r;
  logic qual;
  logic [7:0] thr_ref;

  // Strictly beyond, so the earliest equal value keeps its time stamp
  function automatic logic beyond(input logic [7:0] a, input logic [7:0] b, input logic mn);
    return mn ? ($signed(a) < $signed(b)) : ($signed(a) > $signed(b));
  endfunction : beyond

  assign qual = o_busy && i_tick && time_r >= i_win_start && time_r <= i_win_stop;
  assign thr_ref = i_min_mode ? 8'(-{1'b0, i_thr}) : {1'b0, i_thr};

  always_ff @(posedge i_clk) begin
    if (i_srst || (i_ce && i_clear)) begin
      o_busy <= 1'b0;
      time_r <= 8'h00;
    end else if (i_ce) begin
      if (i_start) begin
        o_busy <= 1'b1;
        time_r <= 8'h00;
      end else if (o_busy && i_tick) begin
        if (time_r == i_win_stop || time_r == crc_pkg::TIMER_LAST) begin
          o_busy <= 1'b0;
        end else begin
          time_r <= time_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || (i_ce && (i_clear || i_start))) begin
      o_peak <= crc_pkg::RES_RST;
      peak_seen_r <= 1'b0;
    end else if (i_ce && qual && (!peak_seen_r || beyond(i_sample, o_peak[7:0], i_min_mode))) begin
      o_peak <= {time_r, i_sample};
      peak_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || (i_ce && (i_clear || i_start))) begin
      o_thr <= crc_pkg::RES_RST;
      thr_seen_r <= 1'b0;
    end else if (i_ce && qual && !thr_seen_r && beyond(i_sample, thr_ref, i_min_mode)) begin
      o_thr <= {time_r, i_sample};
      thr_seen_r <= 1'b1;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_mon_restart: assert property (
    i_ce && i_start && !i_clear |=> o_busy && time_r == 8'h00 && o_peak == 16'h0000)
    else $error("timer not restarted by pulse");
  a_mon_window: assert property (
    $rose(peak_seen_r) |-> $past(time_r) >= $past(i_win_start)
      && $past(time_r) <= $past(i_win_stop))
    else $error("peak taken outside window");
  a_mon_stop: assert property (
    i_ce && o_busy && i_tick && !i_start && time_r == i_win_stop |=> !o_busy)
    else $error("monitor ran past stop");
  a_thr_first: assert property (
    thr_seen_r && i_ce && !i_start && !i_clear |=> $stable(o_thr))
    else $error("threshold result overwritten");

endmodule : crc_monitor

/* src/crc_pkg.sv */
package crc_pkg;

  // Register addresses on the management port
  localparam logic [4:0] ADDR_PAGE = 5'h13;
  localparam logic [4:0] ADDR_CTRL = 5'h16;
  localparam logic [4:0] ADDR_WIN = 5'h17;
  localparam logic [4:0] ADDR_PEAK = 5'h18;
  localparam logic [4:0] ADDR_THR = 5'h19;

  // Page that holds the link-diagnostics registers
  localparam logic [1:0] PAGE_DIAG = 2'h2;
  localparam logic [1:0] PAGE_RST = 2'h0;

  // Field positions of cable_probe_control
  localparam int CTRL_EN = 15;
  localparam int CTRL_SRC100 = 14;
  localparam int CTRL_TX_RX = 13;
  localparam int CTRL_MON_RX = 12;
  localparam int CTRL_SEND = 11;
  localparam int CTRL_WID_LSB = 8;
  localparam int CTRL_MIN = 7;
  localparam int CTRL_THR_LSB = 0;

  // Field positions of probe_sample_window
  localparam int WIN_START_LSB = 8;
  localparam int WIN_STOP_LSB = 0;

  // Values after reset
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] WIN_RST = 16'h00ff;
  localparam logic [15:0] RES_RST = 16'h0000;

  // Sample step and link pulse lengths, in ns and in sample steps
  localparam int STEP_NS = 8;
  localparam int LINK_SHORT_NS = 50;
  localparam int LINK_LONG_NS = 100;
  localparam logic [3:0] LINK_SHORT_STEPS = 4'((LINK_SHORT_NS + STEP_NS - 1) / STEP_NS);
  localparam logic [3:0] LINK_LONG_STEPS = 4'((LINK_LONG_NS + STEP_NS - 1) / STEP_NS);
  // Width codes at or above this give the long link pulse
  localparam logic [2:0] LINK_LONG_CODE = 3'h4;
  localparam logic [7:0] TIMER_LAST = 8'hff;

endpackage : crc_pkg

/* src/crc_pulse.sv */
`timescale 1ns/1ps
module crc_pulse (
  input wire logic i_clk,         // Core clock
  input wire logic i_srst,        // Synchronous reset
  input wire logic i_ce,          // Clock enable
  input wire logic i_start,       // Launch request
  input wire logic i_abort,       // Function disabled
  input wire logic i_tick,        // One 8 ns sample step
  input wire logic i_src100,      // 1: data driver, 0: link driver
  input wire logic [2:0] i_width, // Width code
  output logic o_level,           // Pulse active
  output logic o_neg              // Polarity of data pulse
);

  typedef enum logic [0:0] {PG_IDLE = 1'b0, PG_DRIVE = 1'b1} crc_pg_e;

  crc_pg_e state_r;
  logic [3:0] cnt_r;

  function automatic logic [3:0] width_steps(input logic src100, input logic [2:0] w);
    if (w == 3'h0) return 4'h0;
    if (src100) return {1'b0, w};
    return (w >= crc_pkg::LINK_LONG_CODE) ? crc_pkg::LINK_LONG_STEPS
                                          : crc_pkg::LINK_SHORT_STEPS;
  endfunction : width_steps

  logic [3:0] len;
  assign len = width_steps(i_src100, i_width);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r <= PG_IDLE;
      cnt_r <= 4'h0;
      o_level <= 1'b0;
    end else if (i_ce) begin
      if (i_abort) begin
        state_r <= PG_IDLE;
        o_level <= 1'b0;
      end else if (i_start) begin
        // Zero width sends nothing
        state_r <= (len != 4'h0) ? PG_DRIVE : PG_IDLE;
        o_level <= (len != 4'h0);
        cnt_r <= len;
      end else begin
        unique case (state_r)
          PG_IDLE: o_level <= 1'b0;
          PG_DRIVE: begin
            if (i_tick) begin
              cnt_r <= cnt_r - 4'h1;
              if (cnt_r == 4'h1) begin
                state_r <= PG_IDLE;
                o_level <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end

  // Data pulses take turns in sign
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_neg <= 1'b0;
    end else if (i_ce && !i_abort && i_start && i_src100 && i_width != 3'h0) begin
      o_neg <= ~o_neg;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_pulse_zero: assert property (
    i_ce && i_start && !i_abort && i_width == 3'h0 |=> !o_level)
    else $error("pulse sent with zero width");
  a_pulse_sign: assert property (
    i_ce && i_start && !i_abort && i_src100 && i_width != 3'h0 |=> o_neg != $past(o_neg))
    else $error("data pulse sign did not alternate");

endmodule : crc_pulse

/* src/crc_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - Enable bit hands both drivers to probe.
// - Send bit launches pulse and starts monitor.
// - Bit 14 picks link or data driver.
// - Width bits give 0-7 data sample steps, zero none.
// - Bit 13 picks drive pair, reset transmit.
// - Bit 12 picks sampled pair, reset transmit.
// - Bit 7 tracks maximum or minimum samples.
// - Window upper byte start, lower byte stop.
// - Window resets to start 0, stop 255.
// - Window counts 8 ns steps, 2048 ns.
// - Record extreme and threshold with first time.
// - Peak at 18h, threshold at 19h, read-only.
// - Control and window only on diagnostics page.
// - Zero width still runs the monitor.
// - Timer starts when pulse is launched.
// - Data driver pulses alternate in sign.
// - Link pulse 50/100 ns, data 8 ns steps; link rounds up to 7/13 steps, 56/104 ns.
module crc_top (
  input wire logic I_CORE_CLK,           // Core clock, 200 MHz
  input wire logic I_SRST,               // Synchronous reset, high
  input wire logic I_CE,                 // Clock enable, freezes all state
  input wire logic [4:0] I_REG_ADDR,     // Management register address
  input wire logic I_REG_WR,             // Write strobe
  input wire logic I_REG_RD,             // Read strobe
  input wire logic [15:0] I_REG_WDATA,   // Write data
  output logic [15:0] O_REG_RDATA,       // Read data, one cycle after strobe
  input wire logic I_ADC_VALID,          // One sample per 8 ns step
  input wire logic [7:0] I_ADC_TX_PAIR,  // Signed sample, transmit pair
  input wire logic [7:0] I_ADC_RX_PAIR,  // Signed sample, receive pair
  output logic O_PROBE_ACTIVE,           // Drivers owned by the probe
  output logic O_DRV10_PULSE,            // Link driver pulse
  output logic O_DRV100_PULSE,           // Data driver pulse
  output logic O_DRV100_NEG,             // Data pulse is negative
  output logic O_DRV_ON_RX_PAIR,         // Pulse goes onto the receive pair
  output logic O_MON_BUSY                // Monitor timer running
);

  logic [1:0] page_r;
  logic [15:0] ctrl_r;
  logic [15:0] win_r;
  logic send_r;
  logic [15:0] rd_nxt;
  logic diag_page;
  logic wr_ctrl;
  logic wr_win;
  logic pulse_level;
  logic pulse_neg;
  logic mon_busy;
  logic [15:0] peak_res;
  logic [15:0] thr_res;
  logic [7:0] mon_sample;
  logic enabled;

  assign diag_page = (page_r == crc_pkg::PAGE_DIAG);
  assign wr_ctrl = I_REG_WR && diag_page && I_REG_ADDR == crc_pkg::ADDR_CTRL;
  assign wr_win = I_REG_WR && diag_page && I_REG_ADDR == crc_pkg::ADDR_WIN;
  assign enabled = ctrl_r[crc_pkg::CTRL_EN];

  // Page select is visible on every page
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      page_r <= crc_pkg::PAGE_RST;
    end else if (I_CE && I_REG_WR && I_REG_ADDR == crc_pkg::ADDR_PAGE) begin
      page_r <= I_REG_WDATA[1:0];
    end
  end

  // The send bit is a strobe and is never stored, so it always reads 0
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      ctrl_r <= crc_pkg::CTRL_RST;
    end else if (I_CE && wr_ctrl) begin
      ctrl_r <= I_REG_WDATA & ~(16'h0001 << crc_pkg::CTRL_SEND);
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      win_r <= crc_pkg::WIN_RST;
    end else if (I_CE && wr_win) begin
      win_r <= I_REG_WDATA;
    end
  end

  // A send only counts when the same write also keeps the function enabled
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      send_r <= 1'b0;
    end else if (I_CE) begin
      send_r <= wr_ctrl && I_REG_WDATA[crc_pkg::CTRL_SEND]
                && I_REG_WDATA[crc_pkg::CTRL_EN];
    end
  end

  // Peak and threshold results are read-only; writes there fall away
  always_comb begin
    rd_nxt = 16'h0000;
    if (I_REG_ADDR == crc_pkg::ADDR_PAGE) begin
      rd_nxt = {14'h0000, page_r};
    end else if (diag_page) begin
      unique case (I_REG_ADDR)
        crc_pkg::ADDR_CTRL: rd_nxt = ctrl_r;
        crc_pkg::ADDR_WIN: rd_nxt = win_r;
        crc_pkg::ADDR_PEAK: rd_nxt = peak_res;
        crc_pkg::ADDR_THR: rd_nxt = thr_res;
        default: rd_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_REG_RDATA <= 16'h0000;
    end else if (I_CE && I_REG_RD) begin
      O_REG_RDATA <= rd_nxt;
    end
  end

  // Sampled pair choice
  assign mon_sample = ctrl_r[crc_pkg::CTRL_MON_RX] ? I_ADC_RX_PAIR : I_ADC_TX_PAIR;

  crc_pulse crc_pulse_inst (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_start(send_r),
    .i_abort(!enabled),
    .i_tick(I_ADC_VALID),
    .i_src100(ctrl_r[crc_pkg::CTRL_SRC100]),
    .i_width(ctrl_r[crc_pkg::CTRL_WID_LSB +: 3]),
    .o_level(pulse_level),
    .o_neg(pulse_neg)
  );

  crc_monitor crc_monitor_inst (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_start(send_r),
    .i_clear(!enabled),
    .i_tick(I_ADC_VALID),
    .i_sample(mon_sample),
    .i_win_start(win_r[crc_pkg::WIN_START_LSB +: 8]),
    .i_win_stop(win_r[crc_pkg::WIN_STOP_LSB +: 8]),
    .i_min_mode(ctrl_r[crc_pkg::CTRL_MIN]),
    .i_thr(ctrl_r[crc_pkg::CTRL_THR_LSB +: 7]),
    .o_peak(peak_res),
    .o_thr(thr_res),
    .o_busy(mon_busy)
  );

  assign O_MON_BUSY = mon_busy;

  // Driver takeover; normal line logic must yield while active
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_PROBE_ACTIVE <= 1'b0;
      O_DRV_ON_RX_PAIR <= 1'b0;
    end else if (I_CE) begin
      O_PROBE_ACTIVE <= enabled;
      O_DRV_ON_RX_PAIR <= enabled && ctrl_r[crc_pkg::CTRL_TX_RX];
    end
  end

  // Route the pulse to one driver only; costs one cycle of delay
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_DRV10_PULSE <= 1'b0;
      O_DRV100_PULSE <= 1'b0;
      O_DRV100_NEG <= 1'b0;
    end else if (I_CE) begin
      O_DRV10_PULSE <= enabled && pulse_level && !ctrl_r[crc_pkg::CTRL_SRC100];
      O_DRV100_PULSE <= enabled && pulse_level && ctrl_r[crc_pkg::CTRL_SRC100];
      O_DRV100_NEG <= pulse_neg;
    end
  end

  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  a_page_gate: assert property (
    I_CE && I_REG_WR && !diag_page && I_REG_ADDR == crc_pkg::ADDR_CTRL
      |=> ctrl_r == $past(ctrl_r))
    else $error("control written off the diagnostics page");
  a_take_drivers: assert property (
    I_CE && enabled |=> O_PROBE_ACTIVE)
    else $error("drivers not taken over");
  a_win_gate: assert property (
    I_CE && I_REG_WR && !diag_page && I_REG_ADDR == crc_pkg::ADDR_WIN
      |=> win_r == $past(win_r))
    else $error("window written off the diagnostics page");
  a_send_clear: assert property (
    !ctrl_r[crc_pkg::CTRL_SEND])
    else $error("send bit stored in control");
  a_route_data: assert property (
    I_CE && enabled && pulse_level && ctrl_r[crc_pkg::CTRL_SRC100]
      |=> O_DRV100_PULSE && !O_DRV10_PULSE)
    else $error("data pulse not routed to data driver");
  a_win_reset: assert property (
    $fell(I_SRST) |-> win_r == 16'h00ff)
    else $error("window reset value wrong");
  a_read_peak: assert property (
    I_CE && I_REG_RD && diag_page && I_REG_ADDR == crc_pkg::ADDR_PEAK
      |=> O_REG_RDATA == $past(peak_res))
    else $error("peak read back wrong");
  a_send_start: assert property (
    I_CE && wr_ctrl && I_REG_WDATA[crc_pkg::CTRL_SEND] && I_REG_WDATA[crc_pkg::CTRL_EN]
      ##1 I_CE |=> mon_busy)
    else $error("send did not start monitor");
  a_one_driver: assert property (
    !(O_DRV10_PULSE && O_DRV100_PULSE))
    else $error("both drivers pulsing");
  a_rx_pair: assert property (
    I_CE && !enabled |=> !O_DRV_ON_RX_PAIR)
    else $error("pair select active while disabled");

  c_send_100: cover property (O_DRV100_PULSE);
  c_send_10: cover property (O_DRV10_PULSE);
  c_zero_width: cover property (send_r && ctrl_r[crc_pkg::CTRL_WID_LSB +: 3] == 3'h0);
  c_thr_hit: cover property ($changed(thr_res) && !send_r);

endmodule : crc_top

/* test/crc_cable_model.sv */
`timescale 1ns/1ps
module crc_cable_model #(
  parameter int DLY = 16 // Round trip of the echo, in sample steps
) (
  input wire logic i_clk,   // Core clock
  input wire logic i_drv10, // Link driver pulse
  input wire logic i_drv100, // Data driver pulse
  input wire logic i_neg,   // Data pulse negative
  input wire logic i_on_rx, // Pulse driven onto the receive pair
  output logic o_valid,     // Sample strobe
  output logic [7:0] o_tx,  // Transmit pair sample
  output logic [7:0] o_rx   // Receive pair sample
);
  logic [7:0] echo_r [DLY];
  logic [7:0] direct;
  logic [7:0] bgv;
  logic [7:0] pv;
  logic [2:0] bg_r;
  // Open cable: echo keeps the sign at 60 percent of the launched level
  assign direct = i_drv10 ? 8'h64 : (i_drv100 ? (i_neg ? 8'h9c : 8'h64) : 8'h00);
  // Background never stands still, so a stale capture shows up
  assign bgv = 8'(bg_r) - 8'h02;
  assign pv = (direct != 8'h00) ? direct : ((echo_r[DLY-1] != 8'h00) ? echo_r[DLY-1] : bgv);
  initial begin
    o_valid = 1'b0;
    o_tx = 8'h00;
    o_rx = 8'h00;
    bg_r = 3'h0;
    foreach (echo_r[i]) echo_r[i] = 8'h00;
  end
  always @(negedge i_clk) begin
    bg_r <= (bg_r == 3'h4) ? 3'h0 : bg_r + 3'h1;
    echo_r[0] <= (direct == 8'h64) ? 8'h3c : ((direct == 8'h9c) ? 8'hc4 : 8'h00);
    for (int i = 1; i < DLY; i++) echo_r[i] <= echo_r[i-1];
    o_valid <= 1'b1;
    o_tx <= i_on_rx ? bgv : pv;
    o_rx <= i_on_rx ? pv : bgv;
  end
endmodule : crc_cable_model

/* test/test_cable_reflectometry_control.sv */
`timescale 1ns/1ps
module test_cable_reflectometry_control;
  logic clk, srst, ce, wr, rd, valid, active, d10, d100, neg, onrx, busy, pos, saw, exp_neg;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, rv, pk;
  logic [7:0] s_tx, s_rx;
  int n_errors, samples_checked, c10, c100;
  // Control words: threshold 50, send set; beside them {link count, data count}
  logic [15:0] rows [9] = '{16'h8932, 16'h8b32, 16'h8c32, 16'hbf32, 16'h8832,
                            16'hc932, 16'hff32, 16'hc832, 16'hca32};
  logic [15:0] exp_cnt [9] = '{16'h0700, 16'h0700, 16'h0d00, 16'h0d00, 16'h0000,
                               16'h0001, 16'h0007, 16'h0000, 16'h0002};

  crc_top crc_top_inst (.I_CORE_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_REG_ADDR(addr),
    .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
    .I_ADC_VALID(valid), .I_ADC_TX_PAIR(s_tx), .I_ADC_RX_PAIR(s_rx), .O_PROBE_ACTIVE(active),
    .O_DRV10_PULSE(d10), .O_DRV100_PULSE(d100), .O_DRV100_NEG(neg),
    .O_DRV_ON_RX_PAIR(onrx), .O_MON_BUSY(busy));
  crc_cable_model crc_cable_model_inst (.i_clk(clk), .i_drv10(d10), .i_drv100(d100),
    .i_neg(neg), .i_on_rx(onrx), .o_valid(valid), .o_tx(s_tx), .o_rx(s_rx));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: flag got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  // Launch and count driver cycles until well after the monitor stops
  task automatic run(input logic [15:0] c);
    wr_reg(crc_pkg::ADDR_CTRL, c);
    c10 = 0;
    c100 = 0;
    saw = 1'b0;
    repeat (80) begin
      @(negedge clk);
      c10 += d10;
      c100 += d100;
      saw |= busy;
    end
    if (c[14] && c[10:8] != 3'h0) exp_neg = ~exp_neg;
  endtask : run

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  initial begin
    #40000;
    n_errors++;
    test_done();
  end

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    exp_neg = 1'b0;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    chk_word({11'h000, active, d10, d100, neg, busy}, 16'h0000);
    rd_reg(crc_pkg::ADDR_CTRL, rv);
    chk_word(rv, 16'h0000);
    wr_reg(crc_pkg::ADDR_PAGE, 16'h0002);
    rd_reg(crc_pkg::ADDR_CTRL, rv);
    chk_word(rv, 16'h0000);
    rd_reg(crc_pkg::ADDR_WIN, rv);
    chk_word(rv, 16'h00ff);
    wr_reg(crc_pkg::ADDR_WIN, 16'h0020);
    // Repeated runs, as software is expected to do
    for (int i = 0; i < 9; i++) begin
      run(rows[i]);
      pos = rows[i][10:8] != 3'h0 && !(rows[i][14] && exp_neg);
      chk_word({8'(c10), 8'(c100)}, exp_cnt[i]);
      chk_flag(saw, 1'b1);
      chk_flag(neg, exp_neg);
      chk_flag(onrx, rows[i][13]);
      chk_flag(active, 1'b1);
      chk_flag(busy, 1'b0);
      rd_reg(crc_pkg::ADDR_PEAK, pk);
      chk_word({8'h00, pk[7:0]}, {8'h00, pos ? 8'h64 : 8'h02});
      rd_reg(crc_pkg::ADDR_THR, rv);
      chk_word(rv, pos ? {pk[15:8], 8'h64} : 16'h0000);
    end
    // Min mode while watching the pair that carries no pulse
    run(16'hdab2);
    rd_reg(crc_pkg::ADDR_PEAK, pk);
    chk_word({8'h00, pk[7:0]}, 16'h00fe);
    rd_reg(crc_pkg::ADDR_THR, rv);
    chk_word(rv, 16'h0000);
    // Window opens after the launched pulse, only the echo is seen
    wr_reg(crc_pkg::ADDR_WIN, 16'h0c30);
    run(16'h8932);
    rd_reg(crc_pkg::ADDR_PEAK, pk);
    chk_word({8'h00, pk[7:0]}, 16'h003c);
    chk_flag(pk[15:8] >= 8'h0f && pk[15:8] <= 8'h18, 1'b1);
    rd_reg(crc_pkg::ADDR_THR, rv);
    chk_word(rv, {pk[15:8], 8'h3c});
    repeat (20) @(negedge clk);
    wr_reg(crc_pkg::ADDR_PEAK, 16'h0000);
    rd_reg(crc_pkg::ADDR_PEAK, rv);
    chk_word(rv, pk);
    rd_reg(5'h1c, rv);
    chk_word(rv, 16'h0000);
    rd_reg(crc_pkg::ADDR_CTRL, rv);
    chk_word(rv, 16'h8132);
    // A write while the clock enable is low must leave the window alone
    ce = 1'b0;
    wr_reg(crc_pkg::ADDR_WIN, 16'h1234);
    ce = 1'b1;
    rd_reg(crc_pkg::ADDR_WIN, rv);
    chk_word(rv, 16'h0c30);
    wr_reg(crc_pkg::ADDR_PAGE, 16'h0000);
    rd_reg(crc_pkg::ADDR_CTRL, rv);
    chk_word(rv, 16'h0000);
    wr_reg(crc_pkg::ADDR_PAGE, 16'h0002);
    wr_reg(crc_pkg::ADDR_CTRL, 16'h0000);
    rd_reg(crc_pkg::ADDR_PEAK, rv);
    chk_word(rv, 16'h0000);
    chk_flag(active, 1'b0);
    wr_reg(crc_pkg::ADDR_PAGE, 16'h0000);
    wr_reg(crc_pkg::ADDR_CTRL, 16'h8000);
    repeat (3) @(negedge clk);
    chk_flag(active, 1'b0);
    rd_reg(crc_pkg::ADDR_PAGE, rv);
    chk_word(rv, 16'h0000);
    // Reset in the middle of a run
    wr_reg(crc_pkg::ADDR_PAGE, 16'h0002);
    wr_reg(crc_pkg::ADDR_CTRL, 16'h8932);
    repeat (4) @(negedge clk);
    chk_flag(busy, 1'b1);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk_word({11'h000, active, d10, d100, neg, busy}, 16'h0000);
    rd_reg(crc_pkg::ADDR_PAGE, rv);
    chk_word(rv, 16'h0000);
    wr_reg(crc_pkg::ADDR_PAGE, 16'h0002);
    rd_reg(crc_pkg::ADDR_WIN, rv);
    chk_word(rv, 16'h00ff);
    rd_reg(crc_pkg::ADDR_CTRL, rv);
    chk_word(rv, 16'h0000);
    test_done();
  end
endmodule : test_cable_reflectometry_control
